//--- dv/gpcfg_ctrl_model.sv
`timescale 1ns/1ps
// Display controller on the serial command pins
module gpcfg_ctrl_model
(
  input  wire logic clk,
  output logic      sck,
  output logic      strobe,
  output logic      sdi,
  input  wire logic serial_data_output
);
  initial
  begin
    sck = 1'b0;
    strobe = 1'b0;
    sdi = 1'b0;
  end
  task automatic hold(input int n);
    repeat (n) @(posedge clk);
  endtask
  // Word MSB first, strobe over the last edges
  task automatic cmd(input logic [15:0] w, input int edges);
    for (int i = 15; i >= 0; i--)
    begin
      sdi <= w[i];
      if (i < edges) strobe <= 1'b1;
      hold(5);
      sck <= 1'b1;
      hold(5);
      sck <= 1'b0;
    end
    hold(5);
    strobe <= 1'b0;
    sdi <= ~sdi;
    hold(12);
  endtask
  // Read command, then clock the word out
  task automatic rd(output logic [15:0] w);
    cmd(16'h0000, 5);
    for (int i = 15; i >= 0; i--)
    begin
      w[i] = serial_data_output;
      sck <= 1'b1;
      hold(5);
      sck <= 1'b0;
      hold(8);
    end
  endtask
endmodule

//--- dv/gpcfg_top_bench.sv
`timescale 1ns/1ps
module gpcfg_top_bench;
  import gpcfg_pkg::*;
  logic         clk;
  logic         rst_b;
  logic         sck;
  logic         strobe;
  logic         sdi;
  logic         serial_data_output;
  logic         mult;
  gpcfg_word_t  cfg;
  gpcfg_depth_e depth;
  logic [16:0]  cyc;
  logic [10:0]  sec;
  logic [9:0]   cnt;
  logic [5:0]   lines;
  int           n_fail;
  int           n_compared;
  gpcfg_word_t  expQ[$];
  gpcfg_word_t  w;
  gpcfg_word_t  r;
  gpcfg_word_t  e;
  event         shown;
  gpcfg_top dut (.clk(clk), .rst_b(rst_b), .serialShiftClock(sck), .commandStrobe(strobe),
    .serialDataIn(sdi), .serialDataOutput(serial_data_output), .cfgValue(cfg), .grayDepth(depth),
    .cycleLength(cyc), .sectionLength(sec), .sectionCount(cnt), .scanLines(lines),
    .gclkMultEnable(mult));
  gpcfg_ctrl_model model (.clk(clk), .sck(sck), .strobe(strobe), .sdi(sdi), .serial_data_output(serial_data_output));
  task automatic check(input string what, input logic [16:0] seen, input logic [16:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("CHECK FAILED %s exp %h seen %h", what, exp, seen);
    end
  endtask
  task automatic wrap_up;
    $display("Compared %0d failed %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  task automatic look(input gpcfg_word_t x);
    expQ.push_back(x);
    model.rd(r);
    ->shown;
    repeat (2) @(posedge clk);
  endtask
  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  initial
  begin
    repeat (60000) @(posedge clk);
    n_fail++;
    wrap_up();
  end
  initial forever
  begin
    @(shown);
    e = expQ.pop_front();
    check("readback", r, e);
    check("cfgValue", cfg, e);
    check("grayDepth", depth, e[13:12]);
    check("cycleLength", cyc, 17'h10000 >> e[13:12]);
    check("sectionLength", sec, 17'h00400 >> e[11:10]);
    check("sectionCount", cnt, (17'h10000 >> e[13:12]) / (17'h00400 >> e[11:10]));
    check("scanLines", lines, e[9:5] + 6'h01);
    check("gclkMultEnable", mult, e[4]);
  end
  initial
  begin
    rst_b = 1'b0;
    void'($urandom(32));
    repeat (4) @(posedge clk);
    rst_b <= 1'b1;
    repeat (6) @(posedge clk);
    look(16'h0060);
    model.cmd(16'h3FF0, 4);
    look(16'h0060);
    for (int k = 0; k < 16; k++)
    begin
      w = gpcfg_word_t'($urandom());
      w[13:10] = k[3:0];
      w[3:0] = (k == 15) ? 4'hF : 4'h0;
      model.cmd(16'h0000, 14);
      model.cmd(w, 4);
      look(w);
    end
    w[3:0] = 4'h5;
    model.cmd(16'h0000, 14);
    model.cmd(w, 4);
    look(w);
    model.cmd(16'h0000, 14);
    model.rd(r);
    model.cmd(16'h1234, 4);
    look(w);
    model.cmd(16'h0000, 14);
    model.cmd(16'h0000, 2);
    model.cmd(16'h4321, 4);
    look(w);
    rst_b <= 1'b0;
    repeat (4) @(posedge clk);
    rst_b <= 1'b1;
    repeat (6) @(posedge clk);
    look(16'h0060);
    wrap_up();
  end
endmodule

//--- hw/gpcfg_map.svh
`ifndef GPCFG_MAP_SVH
`define GPCFG_MAP_SVH

// Register reset content
`define GPCFG_RESET_VAL      16'h0060
`define GPCFG_LINES_RESET    6'h04
// Field positions
`define GPCFG_DEPTH_MSB      13
`define GPCFG_DEPTH_LSB      12
`define GPCFG_SPWM_MSB       11
`define GPCFG_SPWM_LSB       10
`define GPCFG_SCAN_MSB       9
`define GPCFG_SCAN_LSB       5
`define GPCFG_MULT_BIT       4
// Decode bases
`define GPCFG_CYCLE_BASE     17'h10000
`define GPCFG_SECT_BASE      11'h400
`define GPCFG_COUNT_BASE     10'h040
// Edge counts that name each command, and the count where the edge counter stops
`define GPCFG_CMD_WRITE      5'h04
`define GPCFG_CMD_READ       5'h05
`define GPCFG_CMD_UNLOCK     5'h0E
`define GPCFG_CNT_MAX        5'h1F

`endif

//--- hw/gpcfg_pkg.sv
package gpcfg_pkg;

  typedef enum logic [1:0]
  {
    GPCFG_DEPTH16 = 2'h0,
    GPCFG_DEPTH15 = 2'h1,
    GPCFG_DEPTH14 = 2'h2,
    GPCFG_DEPTH13 = 2'h3
  } gpcfg_depth_e;

  typedef logic [15:0] gpcfg_word_t;

endpackage

//--- hw/gpcfg_top.sv
`timescale 1ns/1ps
`include "gpcfg_map.svh"
// Overview of operation
// - Depth field D:C picks a PWM cycle of 65536, 32768, 16384 or 8192 grayscale clocks.
// - Field B:A picks sections of 1024, 512, 256 or 128 clocks; sections = cycle / section.
// - Field 9:5 gives the scan line count as code plus one.
// - Scan field resets to 00011, depth and section fields reset to 00.
// - Bit 4 enables the grayscale clock multiplier and resets to zero.
// - The 16-bit register resets to 0x0060 and all fields read and write.
// - A write only takes effect right after a fourteen edge unlock command.
// - Five edges under the strobe shift the register out on the data output, MSB first.
module gpcfg_top
  import gpcfg_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        rst_b,
  input  wire logic        serialShiftClock,
  input  wire logic        commandStrobe,
  input  wire logic        serialDataIn,
  output logic             serialDataOutput,
  output gpcfg_word_t      cfgValue,
  output gpcfg_depth_e     grayDepth,
  output logic [16:0]      cycleLength,
  output logic [10:0]      sectionLength,
  output logic [9:0]       sectionCount,
  output logic [5:0]       scanLines,
  output logic             gclkMultEnable
);

  // ****************************************************************
  // Pin synchronisers
  // ****************************************************************
  logic [2:0]  sclkSync_reg;
  logic [2:0]  strbSync_reg;
  logic [2:0]  dataSync_reg;
  logic        sclkFilt_reg;
  logic        strbFilt_reg;

  always_ff @(posedge clk)
  begin
    if (!rst_b)
    begin
      sclkSync_reg <= 3'h0;
      strbSync_reg <= 3'h0;
      dataSync_reg <= 3'h0;
      sclkFilt_reg <= 1'b0;
      strbFilt_reg <= 1'b0;
    end
    else
    begin
      sclkSync_reg <= {sclkSync_reg[1:0], serialShiftClock};
      strbSync_reg <= {strbSync_reg[1:0], commandStrobe};
      dataSync_reg <= {dataSync_reg[1:0], serialDataIn};
      if (sclkSync_reg[1] == sclkSync_reg[2])
        sclkFilt_reg <= sclkSync_reg[2];
      if (strbSync_reg[1] == strbSync_reg[2])
        strbFilt_reg <= strbSync_reg[2];
    end
  end

  wire sclkRise   = (sclkSync_reg[1] == sclkSync_reg[2]) && sclkSync_reg[2] && !sclkFilt_reg;
  wire strobeFall = (strbSync_reg[1] == strbSync_reg[2]) && !strbSync_reg[2] && strbFilt_reg;
  wire sdiBit     = dataSync_reg[2];

  // ****************************************************************
  // Command decode
  // ****************************************************************
  logic [4:0]   edgeCnt_reg;
  logic [4:0]   edgeCnt_next;
  gpcfg_word_t  shiftIn_reg;
  gpcfg_word_t  shiftOut_reg;
  gpcfg_word_t  shiftOut_next;
  gpcfg_word_t  cfg_reg;
  gpcfg_word_t  cfg_next;
  logic         unlock_reg;
  logic         unlock_next;

  wire cntAtMax   = (edgeCnt_reg == `GPCFG_CNT_MAX);
  wire isUnlock   = strobeFall && (edgeCnt_reg == `GPCFG_CMD_UNLOCK);
  wire isWrite    = strobeFall && (edgeCnt_reg == `GPCFG_CMD_WRITE);
  wire isRead     = strobeFall && (edgeCnt_reg == `GPCFG_CMD_READ);
  wire writeTaken = isWrite && unlock_reg;

  assign edgeCnt_next  = strobeFall ? 5'h00 :
                         (strbFilt_reg && sclkRise && !cntAtMax) ? edgeCnt_reg + 5'h01 :
                         edgeCnt_reg;
  // Any command other than unlock spends the unlock
  assign unlock_next   = strobeFall ? isUnlock : unlock_reg;
  assign cfg_next      = writeTaken ? shiftIn_reg : cfg_reg;
  assign shiftOut_next = isRead ? cfg_reg :
                         (sclkRise && !strbFilt_reg) ? {shiftOut_reg[14:0], 1'b0} :
                         shiftOut_reg;

  always_ff @(posedge clk)
  begin
    if (!rst_b)
    begin
      edgeCnt_reg  <= 5'h00;
      shiftIn_reg  <= 16'h0000;
      shiftOut_reg <= 16'h0000;
      cfg_reg      <= `GPCFG_RESET_VAL;
      unlock_reg   <= 1'b0;
    end
    else
    begin
      edgeCnt_reg  <= edgeCnt_next;
      if (sclkRise)
        shiftIn_reg <= {shiftIn_reg[14:0], sdiBit};
      shiftOut_reg <= shiftOut_next;
      cfg_reg      <= cfg_next;
      unlock_reg   <= unlock_next;
    end
  end

  // ****************************************************************
  // Field decode
  // ****************************************************************
  wire [1:0] depthCode = cfg_reg[`GPCFG_DEPTH_MSB:`GPCFG_DEPTH_LSB];
  wire [1:0] spwmCode  = cfg_reg[`GPCFG_SPWM_MSB:`GPCFG_SPWM_LSB];
  wire [4:0] scanCode  = cfg_reg[`GPCFG_SCAN_MSB:`GPCFG_SCAN_LSB];

  wire [16:0] cycleDec = `GPCFG_CYCLE_BASE >> depthCode;
  wire [10:0] sectDec  = `GPCFG_SECT_BASE >> spwmCode;
  wire [9:0]  countDec = (`GPCFG_COUNT_BASE << spwmCode) >> depthCode;
  wire [5:0]  scanDec  = {1'b0, scanCode} + 6'h01;

  always_ff @(posedge clk)
  begin
    if (!rst_b)
    begin
      cycleLength    <= `GPCFG_CYCLE_BASE;
      sectionLength  <= `GPCFG_SECT_BASE;
      sectionCount   <= `GPCFG_COUNT_BASE;
      scanLines      <= `GPCFG_LINES_RESET;
      gclkMultEnable <= 1'b0;
      grayDepth      <= GPCFG_DEPTH16;
    end
    else
    begin
      cycleLength    <= cycleDec;
      sectionLength  <= sectDec;
      sectionCount   <= countDec;
      scanLines      <= scanDec;
      gclkMultEnable <= cfg_reg[`GPCFG_MULT_BIT];
      grayDepth      <= gpcfg_depth_e'(depthCode);
    end
  end

  assign serialDataOutput = shiftOut_reg[15];
  assign cfgValue         = cfg_reg;

  // ****************************************************************
  // Assertions
  // ****************************************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);

  // Expected decode, one literal per code
  wire [16:0] cycleExp = (depthCode == 2'h0) ? 17'h10000 :
                         (depthCode == 2'h1) ? 17'h08000 :
                         (depthCode == 2'h2) ? 17'h04000 : 17'h02000;
  wire [10:0] sectExp  = (spwmCode == 2'h0) ? 11'h400 :
                         (spwmCode == 2'h1) ? 11'h200 :
                         (spwmCode == 2'h2) ? 11'h100 : 11'h080;
  wire        onlyRsvd = (shiftIn_reg[15:4] == cfg_reg[15:4]);

  sequence unlockSeq;
    strobeFall && (edgeCnt_reg == 5'h0E);
  endsequence

  sequence writeSeq;
    strobeFall && (edgeCnt_reg == 5'h04);
  endsequence

  sequence rsvdWriteSeq;
    writeTaken && onlyRsvd ##1 1'b1;
  endsequence

  // Command checks
  unlock_then_write_a: assert property (unlockSeq ##[1:1000] (writeSeq and unlock_reg)
    ##1 1'b1 |-> cfg_reg == $past(shiftIn_reg)) else $error("Unlocked write not stored");
  locked_write_a: assert property ((isWrite && !unlock_reg) |=> $stable(cfg_reg))
    else $error("Locked write changed register");
  unlock_set_a: assert property (isUnlock |=> unlock_reg)
    else $error("Unlock not armed");
  unlock_spent_a: assert property ((strobeFall && !isUnlock) |=> !unlock_reg)
    else $error("Unlock not spent");
  write_store_a: assert property ((isWrite && unlock_reg)
    |=> cfg_reg == $past(shiftIn_reg)) else $error("Write did not latch last bits");
  cfg_hold_a: assert property (!writeTaken |=> $stable(cfg_reg))
    else $error("Register changed without write");
  read_load_a: assert property (isRead |=> serialDataOutput == $past(cfg_reg[15]))
    else $error("Read did not present MSB");
  read_shift_a: assert property ((sclkRise && !strbFilt_reg)
    |=> serialDataOutput == $past(shiftOut_reg[14])) else $error("Read bit order wrong");

  // Decode checks
  cycle_len_a: assert property (1'b1 |=> cycleLength == $past(cycleExp))
    else $error("Cycle length decode wrong");
  depth_out_a: assert property (1'b1 |=> grayDepth == $past(depthCode))
    else $error("Depth output wrong");
  sect_len_a: assert property (1'b1 |=> sectionLength == $past(sectExp))
    else $error("Section length decode wrong");
  section_prod_a: assert property (1'b1 |-> 27'(sectionCount) * 27'(sectionLength)
    == 27'(cycleLength)) else $error("Sections times length not cycle");
  scan_lines_a: assert property (1'b1 |=> scanLines == 6'($past(scanCode)) + 6'h01)
    else $error("Scan line decode wrong");
  mult_enable_a: assert property (1'b1 |=> gclkMultEnable == $past(cfg_reg[4]))
    else $error("Multiplier enable wrong");
  reserved_free_a: assert property (rsvdWriteSeq |=> $stable(cycleLength)
    && $stable(sectionLength) && $stable(sectionCount) && $stable(scanLines)
    && $stable(gclkMultEnable) && $stable(grayDepth)) else $error("Reserved bits steered logic");

  // Reset checks
  reset_value_a: assert property (disable iff (1'b0) $rose(rst_b)
    |-> cfg_reg == 16'h0060) else $error("Register reset value wrong");
  reset_outs_a: assert property (disable iff (1'b0) $rose(rst_b)
    |-> scanLines == 6'h04 && sectionLength == 11'h400 && grayDepth == GPCFG_DEPTH16
    && !gclkMultEnable) else $error("Decoded reset values wrong");

endmodule
